/* src/dlfp_packer.sv */
// transport-layer frame packer for two 14-bit converters onto two or three lanes
//
// Our own choices: the register offsets and register access over AXI4-Lite.
module dlfp_packer (
    input wire logic clock_i,
    input wire logic rst_i,
    // axi4-lite slave
    input wire logic [7:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [7:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    // sample pair stream from the converter cores
    input wire dlfp_pkg::dlfp_sample_t samp_i,
    input wire logic samp_valid_i,
    output logic samp_ready_o,
    // octets toward the per-lane encoders
    output dlfp_pkg::dlfp_lanes_t lanes_o
);
    ////////////////////////////////////////////////////////////////////////////////
    // register bus
    logic awready_q, awready_d, wready_q, wready_d, bvalid_q, bvalid_d;
    logic arready_q, arready_d, rvalid_q, rvalid_d;
    logic aw_hold_q, aw_hold_d, w_hold_q, w_hold_d, flush_q, flush_d;
    logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
    logic [7:0] awaddr_q, awaddr_d;
    logic [31:0] wdata_q, wdata_d, rdata_q, rdata_d;
    logic [3:0] wstrb_q, wstrb_d;
    logic [1:0] mode_q, mode_d;
    logic [4:0] kenc_q, kenc_d;
    logic [8:0] rate_q, rate_d;
    logic [15:0] frames_q, frames_d;
    logic rate_ok;
    dlfp_pkg::dlfp_params_t p;
    dlfp_pkg::dlfp_params_t pn;

    always_comb begin
        p = dlfp_pkg::mode_params(mode_q);
        pn = dlfp_pkg::mode_params(wdata_q[1:0]);
        rate_ok = (rate_q >= p.rmin) && (rate_q <= p.rmax);
        aw_hold_d = aw_hold_q;
        w_hold_d = w_hold_q;
        awaddr_d = awaddr_q;
        wdata_d = wdata_q;
        wstrb_d = wstrb_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        rvalid_d = rvalid_q;
        rresp_d = rresp_q;
        rdata_d = rdata_q;
        mode_d = mode_q;
        kenc_d = kenc_q;
        rate_d = rate_q;
        flush_d = 1'b0;
        if (s_axi_awvalid_i && awready_q) begin
            aw_hold_d = 1'b1;
            awaddr_d = s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && wready_q) begin
            w_hold_d = 1'b1;
            wdata_d = s_axi_wdata_i;
            wstrb_d = s_axi_wstrb_i;
        end
        if (bvalid_q && s_axi_bready_i) begin
            bvalid_d = 1'b0;
        end
        if (aw_hold_q && w_hold_q && !bvalid_q) begin
            aw_hold_d = 1'b0;
            w_hold_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = dlfp_pkg::RESP_OKAY;
            unique case (awaddr_q)
                dlfp_pkg::REG_CTRL: begin
                    // writing a new mode reprograms the parameter set and flushes the packer
                    if (wstrb_q[0] && (wdata_q[1:0] inside {dlfp_pkg::MODE_EFF3,
                            dlfp_pkg::MODE_EFF2, dlfp_pkg::MODE_SIMPLE2})
                            && wdata_q[1:0] != mode_q) begin
                        mode_d = wdata_q[1:0];
                        flush_d = 1'b1;
                        // k raised to the floor of the new mode
                        if (kenc_q < pn.kmin) begin
                            kenc_d = pn.kmin;
                        end
                    end
                end
                dlfp_pkg::REG_KCFG: begin
                    if (wstrb_q[0]) begin
                        // held encoded, clamped to the mode minimum
                        kenc_d = (wdata_q[4:0] < p.kmin) ? p.kmin : wdata_q[4:0];
                    end
                end
                dlfp_pkg::REG_RATE: begin
                    if (wstrb_q[0]) begin
                        rate_d[7:0] = wdata_q[7:0];
                    end
                    if (wstrb_q[1]) begin
                        rate_d[8] = wdata_q[8];
                    end
                end
                dlfp_pkg::REG_STATUS, dlfp_pkg::REG_PARAM0, dlfp_pkg::REG_PARAM1,
                dlfp_pkg::REG_RATIO: begin
                    bresp_d = dlfp_pkg::RESP_OKAY;
                end
                default: begin
                    bresp_d = dlfp_pkg::RESP_SLVERR;
                end
            endcase
        end
        if (rvalid_q && s_axi_rready_i) begin
            rvalid_d = 1'b0;
        end
        if (s_axi_arvalid_i && arready_q) begin
            rvalid_d = 1'b1;
            rresp_d = dlfp_pkg::RESP_OKAY;
            unique case (s_axi_araddr_i)
                dlfp_pkg::REG_CTRL: rdata_d = {30'h0, mode_q};
                dlfp_pkg::REG_KCFG: rdata_d = {27'h0, kenc_q};
                dlfp_pkg::REG_RATE: rdata_d = {23'h0, rate_q};
                dlfp_pkg::REG_STATUS: rdata_d = {frames_q, 14'h0, p.simple, rate_ok};
                // encoded parameters; CF, CS and HD read as zero
                dlfp_pkg::REG_PARAM0: rdata_d = {16'h0, p.f, p.s, p.l, p.m};
                dlfp_pkg::REG_PARAM1: rdata_d = {16'h0, 3'h0, kenc_q, p.np, p.n};
                dlfp_pkg::REG_RATIO: rdata_d = {15'h0, p.num, p.den};
                default: begin
                    rdata_d = 32'h0;
                    rresp_d = dlfp_pkg::RESP_SLVERR;
                end
            endcase
        end
        awready_d = !aw_hold_d;
        wready_d = !w_hold_d;
        arready_d = !rvalid_d;
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            arready_q <= 1'b0;
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0;
            wstrb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= 2'h0;
            rvalid_q <= 1'b0;
            rresp_q <= 2'h0;
            rdata_q <= 32'h0;
            mode_q <= dlfp_pkg::MODE_RESET;
            kenc_q <= dlfp_pkg::K_RESET;
            rate_q <= dlfp_pkg::RATE_RESET;
            flush_q <= 1'b0;
        end else begin
            awready_q <= awready_d;
            wready_q <= wready_d;
            arready_q <= arready_d;
            aw_hold_q <= aw_hold_d;
            w_hold_q <= w_hold_d;
            awaddr_q <= awaddr_d;
            wdata_q <= wdata_d;
            wstrb_q <= wstrb_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            rvalid_q <= rvalid_d;
            rresp_q <= rresp_d;
            rdata_q <= rdata_d;
            mode_q <= mode_d;
            kenc_q <= kenc_d;
            rate_q <= rate_d;
            flush_q <= flush_d;
        end
    end

    assign s_axi_awready_o = awready_q;
    assign s_axi_wready_o = wready_q;
    assign s_axi_bvalid_o = bvalid_q;
    assign s_axi_bresp_o = bresp_q;
    assign s_axi_arready_o = arready_q;
    assign s_axi_rvalid_o = rvalid_q;
    assign s_axi_rresp_o = rresp_q;
    assign s_axi_rdata_o = rdata_q;

    ////////////////////////////////////////////////////////////////////////////////
    // sample capture and frame emission
    logic [dlfp_pkg::SAMPLE_W-1:0] samp_q [dlfp_pkg::SAMPS_MAX];
    logic [dlfp_pkg::SAMPLE_W-1:0] samp_d [dlfp_pkg::SAMPS_MAX];
    logic [dlfp_pkg::FRAME_W-1:0] frame_q [dlfp_pkg::LANES_MAX];
    logic [dlfp_pkg::FRAME_W-1:0] frame_d [dlfp_pkg::LANES_MAX];
    logic [3:0] cnt_q, cnt_d, oct_q, oct_d;
    logic busy_q, busy_d, ready_q, ready_d, emit_done;
    dlfp_pkg::dlfp_lanes_t lanes_q, lanes_d;
    localparam int PAD_W = dlfp_pkg::FRAME_W - dlfp_pkg::SAMPLE_W - dlfp_pkg::TAIL_W;

    always_comb begin
        samp_d = samp_q;
        frame_d = frame_q;
        cnt_d = cnt_q;
        oct_d = oct_q;
        busy_d = busy_q;
        frames_d = frames_q;
        lanes_d = '0;
        emit_done = !busy_q || (oct_q == p.f);
        if (busy_q) begin
            // one octet per lane per cycle, lanes beyond L idle
            for (int l = 0; l < dlfp_pkg::LANES_MAX; l++) begin
                lanes_d.valid[l] = (4'(l) <= p.l);
                lanes_d.octet[l] = frame_q[l][(dlfp_pkg::FRAME_W - 1
                    - dlfp_pkg::OCTET_W * oct_q) -: dlfp_pkg::OCTET_W];
            end
            lanes_d.frame_start = (oct_q == 4'h0);
            lanes_d.frame_end = (oct_q == p.f);
            oct_d = oct_q + 4'h1;
        end
        if (samp_valid_i && ready_q) begin
            samp_d[cnt_q] = samp_i.c0;
            samp_d[4'(p.s + 4'h1 + cnt_q)] = samp_i.c1;
            cnt_d = cnt_q + 4'h1;
        end
        if (emit_done) begin
            busy_d = 1'b0;
        end
        if (cnt_d == p.s + 4'h1 && emit_done) begin
            // flat order c0s0.., c1s0..; lane l takes the next four, or the next one in simple packing
            for (int l = 0; l < dlfp_pkg::LANES_MAX; l++) begin
                if (p.simple) begin
                    // sample then two tail bits, high octet first
                    frame_d[l] = {samp_d[l], {dlfp_pkg::TAIL_W{1'b0}}, {PAD_W{1'b0}}};
                end else begin
                    // four samples back to back, msb first
                    frame_d[l] = {samp_d[4 * l], samp_d[4 * l + 1],
                                  samp_d[4 * l + 2], samp_d[4 * l + 3]};
                end
            end
            cnt_d = 4'h0;
            oct_d = 4'h0;
            busy_d = 1'b1;
            frames_d = frames_q + 16'h1;
        end
        // stall the source while a full set waits for the emitter
        ready_d = (cnt_d != p.s + 4'h1);
        // mode change drops the partial collection and the frame in flight
        if (flush_q) begin
            cnt_d = 4'h0;
            oct_d = 4'h0;
            busy_d = 1'b0;
            ready_d = 1'b0;
            lanes_d = '0;
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            for (int i = 0; i < dlfp_pkg::SAMPS_MAX; i++) begin
                samp_q[i] <= 14'h0;
            end
            for (int l = 0; l < dlfp_pkg::LANES_MAX; l++) begin
                frame_q[l] <= 56'h0;
            end
            cnt_q <= 4'h0;
            oct_q <= 4'h0;
            busy_q <= 1'b0;
            ready_q <= 1'b0;
            frames_q <= 16'h0;
            lanes_q <= '0;
        end else begin
            samp_q <= samp_d;
            frame_q <= frame_d;
            cnt_q <= cnt_d;
            oct_q <= oct_d;
            busy_q <= busy_d;
            ready_q <= ready_d;
            frames_q <= frames_d;
            lanes_q <= lanes_d;
        end
    end

    assign samp_ready_o = ready_q;
    assign lanes_o = lanes_q;
endmodule : dlfp_packer

/* src/dlfp_pkg.sv */
// shared constants, types and per-mode link parameters of the lane frame packer
package dlfp_pkg;
    localparam int SAMPLE_W = 14;
    localparam int LANES_MAX = 3;
    localparam int SAMPS_MAX = 12;
    localparam int FRAME_W = 56;
    localparam int OCTET_W = 8;
    localparam int TAIL_W = 2;
    localparam int SAMPS_PER_LANE = 4;
    // register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_KCFG = 8'h04;
    localparam logic [7:0] REG_RATE = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0c;
    localparam logic [7:0] REG_PARAM0 = 8'h10;
    localparam logic [7:0] REG_PARAM1 = 8'h14;
    localparam logic [7:0] REG_RATIO = 8'h18;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // packing modes
    localparam logic [1:0] MODE_EFF3 = 2'h0;
    localparam logic [1:0] MODE_EFF2 = 2'h1;
    localparam logic [1:0] MODE_SIMPLE2 = 2'h2;
    localparam logic [1:0] MODE_RESET = MODE_EFF3;
    localparam logic [8:0] RATE_RESET = 9'h0fa;
    localparam logic [4:0] K_RESET = 5'h1f;

    typedef struct packed {
        logic [13:0] c1;
        logic [13:0] c0;
    } dlfp_sample_t;

    typedef struct packed {
        logic frame_start;
        logic frame_end;
        logic [2:0] valid;
        logic [2:0][7:0] octet;
    } dlfp_lanes_t;

    // encoded values are actual minus one; rates in MHz; lane ratio num/den
    typedef struct packed {
        logic [3:0] f;
        logic [3:0] s;
        logic [3:0] l;
        logic [3:0] m;
        logic [3:0] n;
        logic [3:0] np;
        logic [4:0] kmin;
        logic [8:0] rmin;
        logic [8:0] rmax;
        logic [8:0] num;
        logic [7:0] den;
        logic simple;
    } dlfp_params_t;

    function automatic dlfp_params_t mode_params(input logic [1:0] mode);
        dlfp_params_t p;
        p = '{f: 4'h6, s: 4'h5, l: 4'h2, m: 4'h1, n: 4'hd, np: 4'hd, kmin: 5'h02,
              rmin: 9'h064, rmax: 9'h0fa, num: 9'h118, den: 8'h18, simple: 1'b0};
        if (mode == MODE_EFF2) begin
            p = '{f: 4'h6, s: 4'h3, l: 4'h1, m: 4'h1, n: 4'hd, np: 4'hd, kmin: 5'h02,
                  rmin: 9'h039, rmax: 9'h0fa, num: 9'h118, den: 8'h10, simple: 1'b0};
        end else if (mode == MODE_SIMPLE2) begin
            p = '{f: 4'h1, s: 4'h0, l: 4'h1, m: 4'h1, n: 4'hd, np: 4'hf, kmin: 5'h08,
                  rmin: 9'h032, rmax: 9'h0db, num: 9'h140, den: 8'h10, simple: 1'b1};
        end
        return p;
    endfunction : mode_params
endpackage : dlfp_pkg

/* sim/dlfp_packer_chk.sv */
// checker of lane framing and register bus handshakes of the frame packer
module dlfp_packer_chk (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [1:0] s_axi_bresp_o,
    input wire logic s_axi_arvalid_i,
    input wire logic s_axi_arready_o,
    input wire logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    input wire logic [31:0] s_axi_rdata_o,
    input wire logic samp_ready_o,
    input wire dlfp_pkg::dlfp_lanes_t lanes_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////////////////////////////
    // frame ends six octets or one octet after its start
    sequence s_eff_end;
        ##6 lanes_o.frame_end;
    endsequence
    sequence s_smp_end;
        ##1 lanes_o.frame_end;
    endsequence
    a_start_has_octet: assert property (lanes_o.frame_start |-> lanes_o.valid[0])
        else $error("frame start without lane 0 octet");
    a_lane2_with_rest: assert property (lanes_o.valid[2] |-> lanes_o.valid[1:0] == 2'h3)
        else $error("lane 2 octet without lanes 0 and 1");
    a_frame_length: assert property (lanes_o.frame_start |-> s_eff_end or s_smp_end)
        else $error("frame length not seven or two octets");
    a_octets_back2back: assert property
        (lanes_o.valid[0] && !lanes_o.frame_end |=> lanes_o.valid[0])
        else $error("gap inside a frame");
    a_reset_quiet: assert property ($fell(rst_i) |-> lanes_o == '0 && !samp_ready_o)
        else $error("outputs busy right after reset");
    a_bresp_holds: assert property
        (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
        else $error("write response dropped early");
    a_rdata_holds: assert property
        (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
        else $error("read data dropped early");
    a_read_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
        else $error("read answer late");
    a_ar_blocked: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
        else $error("read address taken while answer pending");
endmodule : dlfp_packer_chk

bind dlfp_packer dlfp_packer_chk dlfp_packer_chk_i (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .s_axi_bvalid_o(s_axi_bvalid_o),
    .s_axi_bready_i(s_axi_bready_i),
    .s_axi_bresp_o(s_axi_bresp_o),
    .s_axi_arvalid_i(s_axi_arvalid_i),
    .s_axi_arready_o(s_axi_arready_o),
    .s_axi_rvalid_o(s_axi_rvalid_o),
    .s_axi_rready_i(s_axi_rready_i),
    .s_axi_rdata_o(s_axi_rdata_o),
    .samp_ready_o(samp_ready_o),
    .lanes_o(lanes_o)
);

/* sim/dlfp_lane_rx.sv */
// receiver model: gathers each lane's octets of the current frame
module dlfp_lane_rx (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire dlfp_pkg::dlfp_lanes_t lanes_i,
    output logic [2:0][55:0] frame_o,
    output logic [2:0][3:0] cnt_o,
    output int frames_o
);
    timeunit 1ns;
    timeprecision 1ps;
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            frames_o <= 0;
        end else begin
            for (int l = 0; l < 3; l++) begin
                if (lanes_i.frame_start) begin
                    frame_o[l] <= {48'h0, lanes_i.octet[l]};
                    cnt_o[l] <= {3'h0, lanes_i.valid[l]};
                end else if (lanes_i.valid[l]) begin
                    frame_o[l] <= {frame_o[l][47:0], lanes_i.octet[l]};
                    cnt_o[l] <= cnt_o[l] + 4'h1;
                end
            end
            if (lanes_i.frame_end) begin
                frames_o <= frames_o + 1;
            end
        end
    end
endmodule : dlfp_lane_rx

/* sim/dlfp_packer_tb.sv */
// self-checking testbench of the lane frame packer
module dlfp_packer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock_i, rst_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i;
    logic s_axi_arvalid_i, s_axi_rready_i, samp_valid_i;
    logic [7:0] s_axi_awaddr_i, s_axi_araddr_i;
    logic [31:0] s_axi_wdata_i, s_axi_rdata_o;
    logic [3:0] s_axi_wstrb_i;
    logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o;
    logic s_axi_rvalid_o, samp_ready_o;
    logic [1:0] s_axi_bresp_o, s_axi_rresp_o, r;
    dlfp_pkg::dlfp_sample_t samp_i;
    dlfp_pkg::dlfp_lanes_t lanes_o;
    logic [2:0][55:0] rx_frame;
    logic [2:0][3:0] rx_cnt;
    int rx_frames, n_checks, miscompares, cycles;
    logic [13:0] c0 [6], c1 [6];
    logic [31:0] d;

    dlfp_packer dlfp_packer_i (.clock_i(clock_i), .rst_i(rst_i),
        .s_axi_awaddr_i(s_axi_awaddr_i), .s_axi_awvalid_i(s_axi_awvalid_i),
        .s_axi_awready_o(s_axi_awready_o), .s_axi_wdata_i(s_axi_wdata_i),
        .s_axi_wstrb_i(s_axi_wstrb_i), .s_axi_wvalid_i(s_axi_wvalid_i),
        .s_axi_wready_o(s_axi_wready_o), .s_axi_bresp_o(s_axi_bresp_o),
        .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bready_i(s_axi_bready_i),
        .s_axi_araddr_i(s_axi_araddr_i), .s_axi_arvalid_i(s_axi_arvalid_i),
        .s_axi_arready_o(s_axi_arready_o), .s_axi_rdata_o(s_axi_rdata_o),
        .s_axi_rresp_o(s_axi_rresp_o), .s_axi_rvalid_o(s_axi_rvalid_o),
        .s_axi_rready_i(s_axi_rready_i), .samp_i(samp_i), .samp_valid_i(samp_valid_i),
        .samp_ready_o(samp_ready_o), .lanes_o(lanes_o));
    dlfp_lane_rx dlfp_lane_rx_i (.clock_i(clock_i), .rst_i(rst_i), .lanes_i(lanes_o),
        .frame_o(rx_frame), .cnt_o(rx_cnt), .frames_o(rx_frames));
    ////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [55:0] e, input logic [55:0] g);
        n_checks++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, e, g);
        end
    endtask : chk

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, input int late = 0);
        @(posedge clock_i);
        s_axi_awaddr_i <= a;
        s_axi_wdata_i <= v;
        s_axi_awvalid_i <= 1'b1;
        s_axi_wvalid_i <= 1'b1;
        s_axi_bready_i <= (late == 0);
        do begin
            @(posedge clock_i);
            if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
            if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
        end while (s_axi_bvalid_o !== 1'b1);
        if (late > 0) begin
            // response left waiting so that its hold is exercised
            repeat (late) @(posedge clock_i);
            s_axi_bready_i <= 1'b1;
            @(posedge clock_i);
        end
        s_axi_bready_i <= 1'b0;
        r = s_axi_bresp_o;
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a, input int late = 0);
        @(posedge clock_i);
        s_axi_araddr_i <= a;
        s_axi_arvalid_i <= 1'b1;
        s_axi_rready_i <= (late == 0);
        do begin
            @(posedge clock_i);
            if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
        end while (s_axi_rvalid_o !== 1'b1);
        if (late > 0) begin
            // read data left waiting so that its hold is exercised
            repeat (late) @(posedge clock_i);
            s_axi_rready_i <= 1'b1;
            @(posedge clock_i);
        end
        s_axi_rready_i <= 1'b0;
        d = s_axi_rdata_o;
        r = s_axi_rresp_o;
    endtask : axi_rd

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        axi_rd(a);
        chk("rdata", {24'h0, e}, {24'h0, d});
        chk("rresp", {54'h0, dlfp_pkg::RESP_OKAY}, {54'h0, r});
    endtask : rd_chk

    task automatic send_pairs(input int n);
        int n0;
        n0 = rx_frames;
        for (int k = 0; k < n; k++) begin
            c0[k] = 14'(k * 14'h0b57 + 14'h2001);
            c1[k] = 14'(14'h3fff - k * 14'h0713);
            @(posedge clock_i);
            samp_i <= '{c1: c1[k], c0: c0[k]};
            samp_valid_i <= 1'b1;
            do @(posedge clock_i); while (samp_ready_o !== 1'b1);
            samp_valid_i <= 1'b0;
        end
        while (rx_frames == n0) @(posedge clock_i);
        @(posedge clock_i);
    endtask : send_pairs
    ////////////////////////////////////////////////////////////////
    task automatic t_defaults;
        rd_chk(dlfp_pkg::REG_CTRL, 32'h0);
        rd_chk(dlfp_pkg::REG_PARAM0, 32'h6521);
        rd_chk(dlfp_pkg::REG_PARAM1, 32'h1fdd);
        rd_chk(dlfp_pkg::REG_RATIO, 32'h11818);
        rd_chk(dlfp_pkg::REG_STATUS, 32'h1);
        axi_wr(dlfp_pkg::REG_KCFG, 32'h0);
        chk("bresp", {54'h0, dlfp_pkg::RESP_OKAY}, {54'h0, r});
        rd_chk(dlfp_pkg::REG_PARAM1, 32'h02dd);
        axi_wr(8'h20, 32'h1, 2);
        chk("bresp", {54'h0, dlfp_pkg::RESP_SLVERR}, {54'h0, r});
        axi_rd(8'h20, 3);
        chk("rresp", {54'h0, dlfp_pkg::RESP_SLVERR}, {54'h0, r});
        chk("rdata", 56'h0, {24'h0, d});
        $display("test defaults done");
    endtask : t_defaults

    task automatic t_eff3;
        send_pairs(6);
        chk("lane0", {c0[0], c0[1], c0[2], c0[3]}, rx_frame[0]);
        chk("lane1", {c0[4], c0[5], c1[0], c1[1]}, rx_frame[1]);
        chk("lane2", {c1[2], c1[3], c1[4], c1[5]}, rx_frame[2]);
        chk("octets", {44'h0, 12'h777}, {44'h0, rx_cnt});
        $display("test eff3 done");
    endtask : t_eff3

    task automatic t_eff2;
        axi_wr(dlfp_pkg::REG_CTRL, 32'h1);
        rd_chk(dlfp_pkg::REG_PARAM0, 32'h6311);
        rd_chk(dlfp_pkg::REG_RATIO, 32'h11810);
        send_pairs(4);
        chk("lane0", {c0[0], c0[1], c0[2], c0[3]}, rx_frame[0]);
        chk("lane1", {c1[0], c1[1], c1[2], c1[3]}, rx_frame[1]);
        chk("octets", {44'h0, 12'h077}, {44'h0, rx_cnt});
        $display("test eff2 done");
    endtask : t_eff2

    task automatic t_simple;
        axi_wr(dlfp_pkg::REG_CTRL, 32'h2);
        rd_chk(dlfp_pkg::REG_PARAM0, 32'h1011);
        rd_chk(dlfp_pkg::REG_PARAM1, 32'h08fd);
        rd_chk(dlfp_pkg::REG_RATIO, 32'h14010);
        send_pairs(1);
        chk("lane0", {40'h0, c0[0], 2'b00}, rx_frame[0]);
        chk("lane1", {40'h0, c1[0], 2'b00}, rx_frame[1]);
        chk("octets", {44'h0, 12'h022}, {44'h0, rx_cnt});
        rd_chk(dlfp_pkg::REG_STATUS, 32'h00030002);
        axi_wr(dlfp_pkg::REG_RATE, 32'hdb);
        rd_chk(dlfp_pkg::REG_STATUS, 32'h00030003);
        $display("test simple done");
    endtask : t_simple

    task automatic t_reset;
        @(posedge clock_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clock_i);
        rst_i <= 1'b0;
        rd_chk(dlfp_pkg::REG_CTRL, 32'h0);
        rd_chk(dlfp_pkg::REG_PARAM1, 32'h1fdd);
        rd_chk(dlfp_pkg::REG_STATUS, 32'h1);
        $display("test reset done");
    endtask : t_reset
    ////////////////////////////////////////////////////////////////
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        clock_i = 1'b0;
        forever #4 clock_i = ~clock_i;
    end

    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            tally_and_finish();
        end
    end

    initial begin
        rst_i = 1'b1;
        {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} = 3'h0;
        {s_axi_arvalid_i, s_axi_rready_i, samp_valid_i} = 3'h0;
        {s_axi_awaddr_i, s_axi_araddr_i, s_axi_wdata_i} = '0;
        s_axi_wstrb_i = 4'hf;
        samp_i = '0;
        repeat (2) @(posedge clock_i);
        rst_i <= 1'b0;
        t_defaults();
        t_eff3();
        t_eff2();
        t_simple();
        t_reset();
        tally_and_finish();
    end
endmodule : dlfp_packer_tb
